/* logic/tsc_nv_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface tsc_nv_if;
    logic wrHigh;
    logic wrLow;
    logic wrCfg;
    logic [7:0] wrData;
    logic setHighFlag;
    logic setLowFlag;
    logic factoryLoad;
    logic [7:0] highTrip;
    logic [7:0] lowTrip;
    logic [4:0] cfg;
    logic busy;

    modport ctrl (
        output wrHigh, wrLow, wrCfg, wrData, setHighFlag, setLowFlag,
        output factoryLoad,
        input highTrip, lowTrip, cfg, busy
    );
    modport store (
        input wrHigh, wrLow, wrCfg, wrData, setHighFlag, setLowFlag,
        input factoryLoad,
        output highTrip, lowTrip, cfg, busy
    );
endinterface
`default_nettype wire

/* logic/tsc_nv_store.sv */
`timescale 1ns/10ps
`default_nettype none
// Nonvolatile trip points and option bits; contents survive rst
module tsc_nv_store #(
    parameter int unsigned WRITE_CYCLES = tsc_pkg::NV_WRITE_CYCLES
) (
    input wire logic mclk,
    input wire logic rst,
    tsc_nv_if.store nv
);
    import tsc_pkg::*;

    initial
    begin
        if (WRITE_CYCLES < 1)
            $error("WRITE_CYCLES must be at least 1");
    end

    logic [7:0] high_r, high_nxt;
    logic [7:0] low_r, low_nxt;
    logic [4:0] cfg_r, cfg_nxt;
    logic [31:0] busyCnt_r, busyCnt_nxt;

    always_comb
    begin
        high_nxt = high_r;
        low_nxt = low_r;
        cfg_nxt = cfg_r;
        busyCnt_nxt = busyCnt_r;
        if (busyCnt_r != 32'h0)
            busyCnt_nxt = busyCnt_r - 32'h1;
        if (nv.factoryLoad)
        begin
            high_nxt = FACTORY_HIGH;
            low_nxt = FACTORY_LOW;
            cfg_nxt = FACTORY_CFG;
        end
        else if (busyCnt_r == 32'h0 && (nv.wrHigh || nv.wrLow || nv.wrCfg))
        begin
            if (nv.wrHigh)
                high_nxt = nv.wrData;
            if (nv.wrLow)
                low_nxt = nv.wrData;
            if (nv.wrCfg)
                cfg_nxt = nv.wrData[NV_CFG_W-1:0];
            busyCnt_nxt = WRITE_CYCLES;
        end
        // A hardware trip event wins over a clearing write
        if (nv.setHighFlag)
            cfg_nxt[BIT_HIGH_FLAG] = 1'b1;
        if (nv.setLowFlag)
            cfg_nxt[BIT_LOW_FLAG] = 1'b1;
    end

    // Stored bits carry no reset: a power cycle must not erase them
    always_ff @(posedge mclk)
    begin
        high_r <= high_nxt;
        low_r <= low_nxt;
        cfg_r <= cfg_nxt;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            busyCnt_r <= 32'h0;
        else
            busyCnt_r <= busyCnt_nxt;
    end

    assign nv.highTrip = high_r;
    assign nv.lowTrip = low_r;
    assign nv.cfg = cfg_r;
    assign nv.busy = (busyCnt_r != 32'h0);
endmodule
`default_nettype wire

/* logic/tsc_pkg.sv */
`default_nettype none
package tsc_pkg;
    // Clock rate and documented times
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned NV_WRITE_MS = 10;
    localparam int unsigned NV_WRITE_CYCLES = CLK_HZ / 1000 * NV_WRITE_MS;
    localparam int unsigned POWER_DOWN_S = 10;
    localparam longint unsigned POWER_DOWN_CYCLES =
        longint'(CLK_HZ) * POWER_DOWN_S;
    localparam logic [4:0] RECOVER_PULSES = 5'h10;

    // Function command codes
    localparam logic [7:0] OP_READ_TEMP = 8'hAA;
    localparam logic [7:0] OP_START_CONV = 8'hEE;
    localparam logic [7:0] OP_STOP_CONV = 8'h22;
    localparam logic [7:0] OP_WRITE_HIGH = 8'h01;
    localparam logic [7:0] OP_WRITE_LOW = 8'h02;
    localparam logic [7:0] OP_READ_HIGH = 8'hA1;
    localparam logic [7:0] OP_READ_LOW = 8'hA2;
    localparam logic [7:0] OP_WRITE_STATUS = 8'h0C;
    localparam logic [7:0] OP_READ_STATUS = 8'hAC;
    localparam logic [7:0] OP_READ_COUNT = 8'hA0;
    localparam logic [7:0] OP_COPY_SLOPE = 8'h41;

    // Status and options byte layout
    localparam int BIT_DONE = 7;
    localparam int BIT_ONE = 6;
    localparam int BIT_BUSY = 5;
    localparam int BIT_HIGH_FLAG = 4;
    localparam int BIT_LOW_FLAG = 3;
    localparam int BIT_MODE = 2;
    localparam int BIT_POL = 1;
    localparam int BIT_SINGLE = 0;
    localparam int NV_CFG_W = 5;

    // Factory contents of the nonvolatile store
    localparam logic [7:0] FACTORY_HIGH = 8'h7D;
    localparam logic [7:0] FACTORY_LOW = 8'hC9;
    localparam logic [4:0] FACTORY_CFG = 5'h00;

    typedef enum logic [0:0] {
        TSC_CV_IDLE = 1'b0,
        TSC_CV_BUSY = 1'b1
    } tsc_conv_t;
endpackage
`default_nettype wire

/* logic/tsc_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tsc_top #(
    parameter int unsigned NV_WRITE_CYCLES = tsc_pkg::NV_WRITE_CYCLES,
    parameter longint unsigned POWER_DOWN_CYCLES = tsc_pkg::POWER_DOWN_CYCLES
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic nvFactoryLoad,
    input wire logic supplyLowPin,
    input wire logic dqPinIn,
    output logic dqPinOut,
    output logic dqPinOe,
    input wire logic cmdValid,
    input wire logic [7:0] cmdCode,
    input wire logic [7:0] cmdWrData,
    output logic rspValid,
    output logic [8:0] rspData,
    output logic convStart,
    input wire logic convDone,
    input wire logic [7:0] convTemp,
    input wire logic [8:0] convRemain,
    input wire logic [8:0] convSlope,
    output logic busMode,
    output logic poweredDown,
    output logic thermActive
);
    import tsc_pkg::*;

    initial
    begin
        if (POWER_DOWN_CYCLES < 1)
            $error("POWER_DOWN_CYCLES must be at least 1");
    end

    tsc_nv_if nv ();

    tsc_nv_store #(
        .WRITE_CYCLES(NV_WRITE_CYCLES)
    ) u_store (
        .mclk(mclk),
        .rst(rst),
        .nv(nv)
    );

    // Pin synchronisers
    logic supplyMeta_r, supplyLow_r;
    logic dqMeta_r, dq_r, dqPrev_r;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            supplyMeta_r <= 1'b0;
            supplyLow_r <= 1'b0;
            dqMeta_r <= 1'b1;
            dq_r <= 1'b1;
            dqPrev_r <= 1'b1;
        end
        else
        begin
            supplyMeta_r <= supplyLowPin;
            supplyLow_r <= supplyMeta_r;
            dqMeta_r <= dqPinIn;
            dq_r <= dqMeta_r;
            dqPrev_r <= dq_r;
        end
    end

    logic dqFall;
    assign dqFall = dqPrev_r & ~dq_r;

    // Mode, recovery and power-down state
    logic tempBus_r, tempBus_nxt;
    logic armed_r, armed_nxt;
    logic [4:0] pulseCnt_r, pulseCnt_nxt;
    logic [63:0] pdCnt_r, pdCnt_nxt;
    logic pd_r, pd_nxt;
    logic powerRestart;
    logic thermoMode;

    assign thermoMode = nv.cfg[BIT_MODE] & ~tempBus_r;
    assign busMode = ~thermoMode;
    assign poweredDown = pd_r;
    assign powerRestart = pd_r & ~supplyLow_r;

    always_comb
    begin
        tempBus_nxt = tempBus_r;
        armed_nxt = armed_r;
        pulseCnt_nxt = pulseCnt_r;
        pdCnt_nxt = 64'h0;
        pd_nxt = pd_r;
        if (!supplyLow_r)
        begin
            armed_nxt = 1'b0;
            pulseCnt_nxt = 5'h0;
        end
        else if (!armed_r)
        begin
            armed_nxt = dq_r;
            pulseCnt_nxt = 5'h0;
        end
        else if (dqFall && !pd_r)
        begin
            if (pulseCnt_r == RECOVER_PULSES - 5'h1)
            begin
                // Toggle only the live mode; the stored bit stays
                tempBus_nxt = ~tempBus_r;
                pulseCnt_nxt = 5'h0;
            end
            else
                pulseCnt_nxt = pulseCnt_r + 5'h1;
        end
        if (supplyLow_r && !dq_r && !pd_r)
        begin
            pdCnt_nxt = pdCnt_r + 64'h1;
            if (pdCnt_nxt >= POWER_DOWN_CYCLES)
                pd_nxt = 1'b1;
        end
        if (powerRestart)
        begin
            // Supply back after power down acts as a power cycle
            pd_nxt = 1'b0;
            tempBus_nxt = 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            tempBus_r <= 1'b0;
            armed_r <= 1'b0;
            pulseCnt_r <= 5'h0;
            pdCnt_r <= 64'h0;
            pd_r <= 1'b0;
        end
        else
        begin
            tempBus_r <= tempBus_nxt;
            armed_r <= armed_nxt;
            pulseCnt_r <= pulseCnt_nxt;
            pdCnt_r <= pdCnt_nxt;
            pd_r <= pd_nxt;
        end
    end

    // Conversion control, readings and thermostat
    tsc_conv_t conv_r, conv_nxt;
    logic contRun_r, contRun_nxt;
    logic oneShot_r, oneShot_nxt;
    logic done_r, done_nxt;
    logic start_r, start_nxt;
    logic [7:0] temp_r, temp_nxt;
    logic [8:0] count_r, count_nxt;
    logic [8:0] slope_r, slope_nxt;
    logic active_r, active_nxt;
    logic oe_r, oe_nxt;
    logic rspValid_r, rspValid_nxt;
    logic [8:0] rspData_r, rspData_nxt;
    logic single, cmdTake, run, aboveHigh, belowLow, capture;
    logic [7:0] statusByte;

    assign single = nv.cfg[BIT_SINGLE] & busMode;
    assign cmdTake = cmdValid & busMode & ~pd_r;
    assign run = ~pd_r & (thermoMode | contRun_r | oneShot_r);
    assign capture = (conv_r == TSC_CV_BUSY) & convDone;
    assign aboveHigh = $signed(convTemp) > $signed(nv.highTrip);
    assign belowLow = $signed(convTemp) < $signed(nv.lowTrip);

    always_comb
    begin
        statusByte = '0;
        statusByte[BIT_DONE] = done_r & single;
        statusByte[BIT_ONE] = 1'b1;
        statusByte[BIT_BUSY] = nv.busy;
        statusByte[BIT_HIGH_FLAG:BIT_SINGLE] = nv.cfg;
    end

    always_comb
    begin
        conv_nxt = conv_r;
        contRun_nxt = contRun_r;
        oneShot_nxt = oneShot_r;
        done_nxt = done_r;
        start_nxt = 1'b0;
        temp_nxt = temp_r;
        count_nxt = count_r;
        slope_nxt = slope_r;
        active_nxt = active_r;
        rspValid_nxt = 1'b0;
        rspData_nxt = rspData_r;
        nv.wrHigh = 1'b0;
        nv.wrLow = 1'b0;
        nv.wrCfg = 1'b0;
        nv.wrData = cmdWrData;
        nv.setHighFlag = 1'b0;
        nv.setLowFlag = 1'b0;
        nv.factoryLoad = nvFactoryLoad;
        unique case (conv_r)
            TSC_CV_IDLE:
            begin
                if (run)
                begin
                    start_nxt = 1'b1;
                    conv_nxt = TSC_CV_BUSY;
                end
            end
            TSC_CV_BUSY:
            begin
                if (convDone)
                begin
                    conv_nxt = TSC_CV_IDLE;
                    temp_nxt = convTemp;
                    count_nxt = convRemain;
                    slope_nxt = convSlope;
                    if (oneShot_r)
                    begin
                        oneShot_nxt = 1'b0;
                        done_nxt = 1'b1;
                    end
                end
            end
        endcase
        if (capture)
        begin
            nv.setHighFlag = aboveHigh;
            nv.setLowFlag = belowLow;
            if (aboveHigh)
                active_nxt = 1'b1;
            else if (belowLow)
                active_nxt = 1'b0;
        end
        if (cmdTake)
        begin
            unique case (cmdCode)
                OP_START_CONV:
                begin
                    if (single)
                    begin
                        oneShot_nxt = 1'b1;
                        done_nxt = 1'b0;
                    end
                    else
                        contRun_nxt = 1'b1;
                end
                OP_STOP_CONV:
                begin
                    if (!single)
                        contRun_nxt = 1'b0;
                end
                OP_COPY_SLOPE:
                    count_nxt = slope_r;
                OP_WRITE_HIGH:
                    nv.wrHigh = 1'b1;
                OP_WRITE_LOW:
                    nv.wrLow = 1'b1;
                OP_WRITE_STATUS:
                    nv.wrCfg = 1'b1;
                OP_READ_TEMP:
                begin
                    rspValid_nxt = 1'b1;
                    rspData_nxt = {1'b0, temp_r};
                end
                OP_READ_HIGH:
                begin
                    rspValid_nxt = 1'b1;
                    rspData_nxt = {1'b0, nv.highTrip};
                end
                OP_READ_LOW:
                begin
                    rspValid_nxt = 1'b1;
                    rspData_nxt = {1'b0, nv.lowTrip};
                end
                OP_READ_STATUS:
                begin
                    rspValid_nxt = 1'b1;
                    rspData_nxt = {1'b0, statusByte};
                end
                OP_READ_COUNT:
                begin
                    rspValid_nxt = 1'b1;
                    rspData_nxt = count_r;
                end
                default:
                    rspValid_nxt = 1'b0;
            endcase
        end
        if (!busMode || powerRestart)
        begin
            contRun_nxt = 1'b0;
            oneShot_nxt = 1'b0;
            done_nxt = 1'b0;
        end
        // Pull the pin low whenever the output level should be 0
        oe_nxt = thermoMode & ~pd_r
            & (nv.cfg[BIT_POL] ? ~active_nxt : active_nxt);
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            conv_r <= TSC_CV_IDLE;
            contRun_r <= 1'b0;
            oneShot_r <= 1'b0;
            done_r <= 1'b0;
            start_r <= 1'b0;
            temp_r <= 8'h00;
            count_r <= 9'h000;
            slope_r <= 9'h000;
            active_r <= 1'b0;
            oe_r <= 1'b0;
            rspValid_r <= 1'b0;
            rspData_r <= 9'h000;
        end
        else
        begin
            conv_r <= conv_nxt;
            contRun_r <= contRun_nxt;
            oneShot_r <= oneShot_nxt;
            done_r <= done_nxt;
            start_r <= start_nxt;
            temp_r <= temp_nxt;
            count_r <= count_nxt;
            slope_r <= slope_nxt;
            active_r <= active_nxt;
            oe_r <= oe_nxt;
            rspValid_r <= rspValid_nxt;
            rspData_r <= rspData_nxt;
        end
    end

    assign convStart = start_r;
    assign dqPinOut = 1'b0;
    assign dqPinOe = oe_r;
    assign thermActive = active_r;
    assign rspValid = rspValid_r;
    assign rspData = rspData_r;
endmodule
`default_nettype wire

/* verification/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import tsc_pkg::*;
    logic mclk, rst, nvFactoryLoad, supplyLowPin, dqDrive, dqPinIn;
    logic cmdValid, dqPinOut, dqPinOe, rspValid, convStart, convDone;
    logic busMode, poweredDown, thermActive;
    logic [7:0] cmdCode, cmdWrData, temp, convTemp, rndTh;
    logic [8:0] rspData, convRemain, convSlope, remain, slope, e;
    logic [31:0] lfsr = 32'h00015CB9;
    logic [8:0] expQ[$];
    int errTotal = 0, nChecks = 0, starts, n;

    assign dqPinIn = dqDrive & ~dqPinOe;
    tsc_top #(.NV_WRITE_CYCLES(5), .POWER_DOWN_CYCLES(20)) i_dut (
        .mclk(mclk), .rst(rst), .nvFactoryLoad(nvFactoryLoad),
        .supplyLowPin(supplyLowPin), .dqPinIn(dqPinIn),
        .dqPinOut(dqPinOut), .dqPinOe(dqPinOe), .cmdValid(cmdValid),
        .cmdCode(cmdCode), .cmdWrData(cmdWrData), .rspValid(rspValid),
        .rspData(rspData), .convStart(convStart), .convDone(convDone),
        .convTemp(convTemp), .convRemain(convRemain),
        .convSlope(convSlope), .busMode(busMode),
        .poweredDown(poweredDown), .thermActive(thermActive));
    tsc_core_model i_core (
        .mclk(mclk), .rst(rst), .convStart(convStart), .temp(temp),
        .remain(remain), .slope(slope), .convDone(convDone),
        .convTemp(convTemp), .convRemain(convRemain),
        .convSlope(convSlope), .starts(starts));

    function automatic logic [31:0] nextRnd(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic tick(input int k);
        repeat (k)
        begin
            @(posedge mclk);
            #1;
        end
    endtask
    task automatic chk(input string what, input logic [8:0] ex,
                       input logic [8:0] seen);
        nChecks++;
        if (seen !== ex)
        begin
            errTotal++;
            $display("MISMATCH %s expected %h seen %h", what, ex, seen);
        end
    endtask
    task automatic cmd(input logic [7:0] c, input logic [7:0] d);
        cmdCode = c;
        cmdWrData = d;
        cmdValid = 1'b1;
        tick(1);
        cmdValid = 1'b0;
        tick(1);
    endtask
    task automatic rd(input logic [7:0] c, input logic [8:0] ex);
        expQ.push_back(ex);
        cmd(c, 8'h00);
    endtask
    task automatic waitConv();
        int k;
        for (k = 0; k < 60 && convDone !== 1'b1; k++)
            tick(1);
        chk("convDone", 9'h001, 9'(convDone));
        tick(1);
    endtask
    // Pin is pulled low whenever the output level should read 0
    task automatic thermo(input logic [7:0] t, input logic act,
                          input logic output_active_level);
        temp = t;
        waitConv();
        waitConv();
        tick(3);
        chk("thermActive", 9'(act), 9'(thermActive));
        chk("dqPinOe", 9'(act ^ output_active_level), 9'(dqPinOe));
    endtask
    task automatic recover();
        supplyLowPin = 1'b1;
        dqDrive = 1'b1;
        tick(4);
        repeat (16)
        begin
            dqDrive = 1'b0;
            tick(3);
            dqDrive = 1'b1;
            tick(3);
        end
        supplyLowPin = 1'b0;
        tick(4);
    endtask
    task automatic giveVerdict();
        $display("checks %0d mismatches %0d", nChecks, errTotal);
        if (errTotal == 0 && nChecks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    always @(negedge mclk)
        if (rspValid === 1'b1)
        begin
            if (expQ.size() == 0)
                chk("unexpected rspValid", 9'h000, 9'(rspValid));
            else
            begin
                e = expQ.pop_front();
                chk("rspData", e, rspData);
            end
        end

    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    initial
    begin
        repeat (4000) @(posedge mclk);
        errTotal++;
        $display("MISMATCH watchdog expected finish seen timeout");
        giveVerdict();
    end

    initial
    begin
        {rst, nvFactoryLoad, dqDrive} = 3'h7;
        {supplyLowPin, cmdValid, cmdCode, cmdWrData} = 18'h00000;
        {temp, remain, slope} = 26'h0000000;
        repeat (8) @(posedge mclk);
        #1;
        {rst, nvFactoryLoad} = 2'h0;
        tick(2);
        chk("busMode", 9'h001, 9'(busMode));
        rd(OP_READ_STATUS, 9'h040);
        rd(OP_READ_HIGH, 9'h07D);
        rd(OP_READ_LOW, 9'h0C9);
        lfsr = nextRnd(lfsr);
        rndTh = lfsr[7:0];
        cmd(OP_WRITE_HIGH, rndTh);
        rd(OP_READ_STATUS, 9'h060);
        tick(8);
        rd(OP_READ_HIGH, {1'b0, rndTh});
        cmd(OP_WRITE_HIGH, 8'h19);
        tick(8);
        cmd(OP_WRITE_LOW, 8'h00);
        tick(8);
        cmd(OP_WRITE_STATUS, 8'h01);
        tick(8);
        lfsr = nextRnd(nextRnd(lfsr));
        {remain, slope, temp} = {lfsr[17:0], 8'h1E};
        cmd(OP_START_CONV, 8'h00);
        rd(OP_READ_STATUS, 9'h041);
        waitConv();
        n = starts;
        tick(20);
        chk("oneShotStarts", 9'(n), 9'(starts));
        rd(OP_READ_STATUS, 9'h0D1);
        rd(OP_READ_TEMP, 9'h01E);
        rd(OP_READ_COUNT, remain);
        cmd(OP_COPY_SLOPE, 8'h00);
        rd(OP_READ_COUNT, slope);
        cmd(OP_WRITE_STATUS, 8'h01);
        tick(8);
        temp = 8'hF6;
        cmd(OP_START_CONV, 8'h00);
        waitConv();
        rd(OP_READ_STATUS, 9'h0C9);
        cmd(OP_WRITE_STATUS, 8'h00);
        tick(8);
        temp = 8'h05;
        cmd(OP_START_CONV, 8'h00);
        waitConv();
        waitConv();
        rd(OP_READ_STATUS, 9'h040);
        cmd(OP_STOP_CONV, 8'h00);
        tick(10);
        n = starts;
        tick(30);
        chk("stoppedStarts", 9'(n), 9'(starts));
        cmd(OP_WRITE_STATUS, 8'h06);
        tick(8);
        rst = 1'b1;
        tick(8);
        rst = 1'b0;
        tick(2);
        chk("busMode", 9'h000, 9'(busMode));
        thermo(8'h30, 1'b1, 1'b1);
        thermo(8'h0A, 1'b1, 1'b1);
        thermo(8'hF0, 1'b0, 1'b1);
        thermo(8'h30, 1'b1, 1'b1);
        recover();
        chk("busMode", 9'h001, 9'(busMode));
        rd(OP_READ_STATUS, 9'h05E);
        cmd(OP_WRITE_STATUS, 8'h04);
        rd(OP_READ_STATUS, 9'h064);
        tick(4);
        recover();
        chk("busMode", 9'h000, 9'(busMode));
        thermo(8'hF0, 1'b0, 1'b0);
        thermo(8'h30, 1'b1, 1'b0);
        {supplyLowPin, dqDrive} = 2'h2;
        tick(30);
        chk("poweredDown", 9'h001, 9'(poweredDown));
        cmd(OP_READ_STATUS, 8'h00);
        {supplyLowPin, dqDrive} = 2'h1;
        tick(6);
        chk("poweredDown", 9'h000, 9'(poweredDown));
        chk("pendingReads", 9'h000, 9'(expQ.size()));
        giveVerdict();
    end
endmodule
`default_nettype wire

/* verification/tsc_core_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Analog conversion core: answers each start after DELAY cycles
module tsc_core_model #(
    parameter int DELAY = 6
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic convStart,
    input wire logic [7:0] temp,
    input wire logic [8:0] remain,
    input wire logic [8:0] slope,
    output logic convDone,
    output logic [7:0] convTemp,
    output logic [8:0] convRemain,
    output logic [8:0] convSlope,
    output int starts
);
    int waitCnt;

    always @(posedge mclk or posedge rst)
        if (rst)
        begin
            waitCnt <= 0;
            convDone <= 1'b0;
            starts <= 0;
        end
        else
        begin
            convDone <= (waitCnt == 1);
            if (convStart)
            begin
                waitCnt <= DELAY;
                starts <= starts + 1;
            end
            else if (waitCnt > 0)
                waitCnt <= waitCnt - 1;
        end
    // Data is only valid with convDone; garbage otherwise
    assign convTemp = convDone ? temp : ~temp;
    assign convRemain = convDone ? remain : ~remain;
    assign convSlope = convDone ? slope : ~slope;
endmodule
`default_nettype wire

/* verification/tsc_top_props.sv */
`timescale 1ns/10ps
`default_nettype none
module tsc_top_props #(
    parameter longint unsigned POWER_DOWN_CYCLES = tsc_pkg::POWER_DOWN_CYCLES
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic supplyLowPin,
    input wire logic dqPinIn,
    input wire logic dqPinOut,
    input wire logic dqPinOe,
    input wire logic cmdValid,
    input wire logic [7:0] cmdCode,
    input wire logic rspValid,
    input wire logic convStart,
    input wire logic convDone,
    input wire logic busMode,
    input wire logic poweredDown,
    input wire logic thermActive
);
    import tsc_pkg::*;
    longint unsigned lowCnt_r;
    longint unsigned lowCnt_nxt;

    // Consecutive cycles of supply low with the wire low
    always_comb
        lowCnt_nxt = (supplyLowPin && !dqPinIn) ? lowCnt_r + 1 : 0;
    always_ff @(posedge mclk or posedge rst)
        if (rst)
            lowCnt_r <= 0;
        else
            lowCnt_r <= lowCnt_nxt;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    rd_answer_a: assert property (
        cmdValid && busMode && !poweredDown && cmdCode == OP_READ_TEMP
        |=> rspValid) else $error("temperature read not answered");
    rsp_cause_a: assert property (
        rspValid |-> $past(cmdValid) && $past(busMode) && !$past(poweredDown))
        else $error("response without accepted command");
    therm_silent_a: assert property (
        cmdValid && !busMode |=> !rspValid)
        else $error("command answered in thermostat mode");
    pin_therm_only_a: assert property (
        busMode && $past(busMode) |-> !dqPinOe)
        else $error("pin driven in bus mode");
    pin_low_only_a: assert property (
        dqPinOe |-> !dqPinOut) else $error("pin driven high");
    conv_pulse_a: assert property (
        convStart |=> !convStart) else $error("start pulse too long");
    therm_hold_a: assert property (
        $changed(thermActive) && !poweredDown && !$past(poweredDown)
        |-> $past(convDone)) else $error("output changed without result");
    power_down_a: assert property (
        $rose(poweredDown) |-> lowCnt_r >= POWER_DOWN_CYCLES)
        else $error("power down too early");
    dead_silent_a: assert property (
        poweredDown && cmdValid |=> !rspValid)
        else $error("command answered while powered down");
endmodule
bind tsc_top tsc_top_props #(.POWER_DOWN_CYCLES(POWER_DOWN_CYCLES)) i_props (
    .mclk(mclk),
    .rst(rst),
    .supplyLowPin(supplyLowPin),
    .dqPinIn(dqPinIn),
    .dqPinOut(dqPinOut),
    .dqPinOe(dqPinOe),
    .cmdValid(cmdValid),
    .cmdCode(cmdCode),
    .rspValid(rspValid),
    .convStart(convStart),
    .convDone(convDone),
    .busMode(busMode),
    .poweredDown(poweredDown),
    .thermActive(thermActive)
);
`default_nettype wire
